// ==== src/rx_cfg_rom_regs.sv ====
// register block: receive configuration word and serial rom command byte,
// with the receive decisions those registers steer
// assumes the mac presents one packet verdict request per pkt_valid pulse
// and that the rom data-out pin and rom type strap are asynchronous pins
//
// Implementation choice: the strobed register port.
module rx_cfg_rom_regs
  import rx_cfg_pkg::*;
#(
  parameter int AUTOLOAD_LEN = rx_cfg_pkg::AUTOLOAD_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // receive path
  input wire logic pkt_valid,
  input wire rx_cfg_pkg::rx_pkt_t pkt,
  output logic verdict_valid,
  output logic pkt_accept,
  output logic crc_check,
  input wire logic [15:0] fifo_bytes,
  input wire logic fifo_pkt_complete,
  output logic dma_start,
  output logic [10:0] burst_bytes,
  output logic burst_unlimited,
  // system control
  output logic bus_master_en,
  output logic setup_write_en,
  output logic regs_default,
  input wire logic flash_sel,
  input wire logic boot_rom_done,
  input wire logic rom_type_pin,
  // serial rom pins
  output rx_cfg_pkg::rom_pins_t rom_pins,
  input wire logic serial_rom_dout
);
  import rx_cfg_pkg::*;

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  // the reload timer is 17 bits; a longer reload needs a wider counter
  if (AUTOLOAD_LEN < 1 || AUTOLOAD_LEN >= (1 << 17)) begin : g_len_check
    $error("AUTOLOAD_LEN out of range for the 17-bit timer");
  end

  // size code to byte count; zero for reserved codes and for 111
  function automatic logic [10:0] size_bytes(input logic [2:0] code);
    logic [10:0] b;
    b = 11'h000;
    if (code >= SIZE_64 && code < SIZE_NONE) begin
      b = 11'h040 << (code - SIZE_64);
    end
    return b;
  endfunction

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] dout_sync_r, dout_sync_nxt;
  logic [1:0] type_sync_r, type_sync_nxt;

  // two stages each; only the second stage is read by logic
  always_comb begin
    dout_sync_nxt = {dout_sync_r[0], serial_rom_dout};
    type_sync_nxt = {type_sync_r[0], rom_type_pin};
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dout_sync_r <= 2'h0;
      type_sync_r <= 2'h0;
    end else begin
      dout_sync_r <= dout_sync_nxt;
      type_sync_r <= type_sync_nxt;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [31:0] rx_cfg_r, rx_cfg_nxt;
  rom_mode_t mode_r, mode_nxt;
  rom_pins_t pins_r, pins_nxt;
  logic rom_type_r, rom_type_nxt;
  logic [16:0] load_cnt_r, load_cnt_nxt;
  logic regs_default_r, regs_default_nxt;
  logic [1:0] strap_cnt_r, strap_cnt_nxt;
  logic busy;
  logic wr_cfg;
  logic wr_cmd;

  assign busy = (mode_r == MODE_AUTOLOAD);
  assign wr_cfg = wr && addr == RX_CFG_OFF && !busy;
  assign wr_cmd = wr && addr == ROM_CMD_OFF && !busy;

  // register writes and the auto-load sequence; writes are ignored
  // while the reload runs so software cannot race the defaults
  always_comb begin
    rx_cfg_nxt = rx_cfg_r;
    mode_nxt = mode_r;
    pins_nxt = pins_r;
    rom_type_nxt = rom_type_r;
    load_cnt_nxt = load_cnt_r;
    regs_default_nxt = 1'b0;
    // strap is caught once the synchroniser has filled after reset
    if (strap_cnt_r == 2'h2) begin
      rom_type_nxt = type_sync_r[1];
    end
    if (wr_cfg) begin
      rx_cfg_nxt = wdata & RX_CFG_WMASK;
    end
    if (wr_cmd) begin
      mode_nxt = rom_mode_t'(wdata[MODE_LSB +: 2]);
      pins_nxt.serial_rom_select = wdata[SEL_BIT];
      pins_nxt.serial_rom_clock = wdata[CLK_BIT];
      pins_nxt.serial_rom_din = wdata[DIN_BIT];
      load_cnt_nxt = 17'(AUTOLOAD_LEN - 1);
    end
    if (busy) begin
      if (load_cnt_r == 17'h0_0000) begin
        // reload done: back to normal, everything to defaults
        mode_nxt = MODE_NORMAL;
        rx_cfg_nxt = RX_CFG_RESET;
        pins_nxt = '0;
        rom_type_nxt = type_sync_r[1];
        regs_default_nxt = 1'b1;
      end else begin
        load_cnt_nxt = load_cnt_r - 17'h0_0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_cfg_r <= RX_CFG_RESET;
      mode_r <= MODE_NORMAL;
      pins_r <= '0;
      rom_type_r <= 1'b0;
      load_cnt_r <= 17'h0_0000;
      regs_default_r <= 1'b0;
    end else begin
      rx_cfg_r <= rx_cfg_nxt;
      mode_r <= mode_nxt;
      pins_r <= pins_nxt;
      rom_type_r <= rom_type_nxt;
      load_cnt_r <= load_cnt_nxt;
      regs_default_r <= regs_default_nxt;
    end
  end

  // strap capture: count two edges after release so the second
  // synchroniser stage already holds the pin when it is latched;
  // each reload latches it again
  logic rom_type_q;

  always_comb begin
    strap_cnt_nxt = strap_cnt_r;
    if (strap_cnt_r != 2'h3) begin
      strap_cnt_nxt = strap_cnt_r + 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      strap_cnt_r <= 2'h0;
    end else begin
      strap_cnt_r <= strap_cnt_nxt;
    end
  end

  // until the capture the live synchroniser output is shown
  assign rom_type_q = (strap_cnt_r == 2'h3) ? rom_type_r : type_sync_r[1];

  // ---------------------------------------------------------------
  // field views
  // ---------------------------------------------------------------
  logic sfcc, aerr, arunt;
  logic [2:0] thr_code, burst_code;

  assign sfcc = rx_cfg_r[SFCC_BIT];
  assign aerr = rx_cfg_r[AERR_BIT];
  assign arunt = rx_cfg_r[ARUNT_BIT];
  assign thr_code = rx_cfg_r[THR_LSB +: 3];
  assign burst_code = rx_cfg_r[BURST_LSB +: 3];

  // mode-driven controls; programming mode owns the rom and halts dma
  assign bus_master_en = (mode_r == MODE_NORMAL || mode_r == MODE_CFG_WRITE);
  assign setup_write_en = (mode_r == MODE_CFG_WRITE);
  assign regs_default = regs_default_r;
  assign rom_pins = (mode_r == MODE_PROGRAM) ? pins_r : '0;
  assign burst_bytes = size_bytes(burst_code);
  assign burst_unlimited = (burst_code == SIZE_NONE);

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  logic [31:0] rdata_r, rdata_nxt;
  logic pin_vis;
  logic late_vis;

  assign pin_vis = (mode_r == MODE_AUTOLOAD || mode_r == MODE_PROGRAM) && !flash_sel;
  assign late_vis = pin_vis && boot_rom_done;

  // one cycle read latency; unmapped addresses read zero
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (rd) begin
      case (addr)
        RX_CFG_OFF: begin
          rdata_nxt = rx_cfg_r;
          rdata_nxt[ROM_TYPE_BIT] = rom_type_q;
        end
        ROM_CMD_OFF: begin
          rdata_nxt[MODE_LSB +: 2] = mode_r;
          rdata_nxt[SEL_BIT] = pin_vis & rom_pins.serial_rom_select;
          rdata_nxt[CLK_BIT] = late_vis & rom_pins.serial_rom_clock;
          rdata_nxt[DIN_BIT] = late_vis & rom_pins.serial_rom_din;
          rdata_nxt[DOUT_BIT] = late_vis & dout_sync_r[1];
        end
        default: begin
          rdata_nxt = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata = rdata_r;

  // ---------------------------------------------------------------
  // receive verdict
  // ---------------------------------------------------------------
  logic verdict_valid_r, verdict_valid_nxt;
  logic accept_r, accept_nxt;
  logic crc_r, crc_nxt;
  logic is_err, is_runt, addr_ok, err_ok, runt_ok;

  // any one fault marks the packet errored; they are not told apart
  assign is_err = pkt.crc_err | pkt.align_err | pkt.collided;
  assign is_runt = pkt.len < MIN_LEN;
  assign err_ok = !is_err || aerr;
  assign runt_ok = !is_runt || (arunt && pkt.len >= SHORT_LEN);
  // broadcast, multicast, own address, or promiscuous
  assign addr_ok = (pkt.is_bcast & rx_cfg_r[ABC_BIT])
    | (pkt.is_mcast & rx_cfg_r[AMC_BIT])
    | (pkt.phys_match & rx_cfg_r[APM_BIT])
    | rx_cfg_r[AALL_BIT];

  // crc window widens to 8 bytes when errored or small frames may be kept, or when sfcc is set
  always_comb begin
    verdict_valid_nxt = pkt_valid;
    accept_nxt = 1'b0;
    crc_nxt = 1'b0;
    if (pkt_valid) begin
      accept_nxt = addr_ok && err_ok && runt_ok;
      if (aerr || arunt) begin
        crc_nxt = pkt.len > SHORT_LEN;
      end else if (sfcc) begin
        crc_nxt = pkt.len > SHORT_LEN;
      end else begin
        crc_nxt = pkt.len > MIN_LEN;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      verdict_valid_r <= 1'b0;
      accept_r <= 1'b0;
      crc_r <= 1'b0;
    end else begin
      verdict_valid_r <= verdict_valid_nxt;
      accept_r <= accept_nxt;
      crc_r <= crc_nxt;
    end
  end

  assign verdict_valid = verdict_valid_r;
  assign pkt_accept = accept_r;
  assign crc_check = crc_r;

  // ---------------------------------------------------------------
  // dma start threshold
  // ---------------------------------------------------------------
  logic dma_start_r, dma_start_nxt;
  logic [10:0] thr_bytes;

  // reserved codes behave like 111 (whole packet) as the safe choice
  assign thr_bytes = size_bytes(thr_code);

  // a halted bus master never starts, even with a whole packet held
  always_comb begin
    dma_start_nxt = 1'b0;
    if (bus_master_en) begin
      if (fifo_pkt_complete) begin
        dma_start_nxt = 1'b1;
      end else if (thr_bytes != 11'h000 && fifo_bytes >= {5'h00, thr_bytes}) begin
        dma_start_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dma_start_r <= 1'b0;
    end else begin
      dma_start_r <= dma_start_nxt;
    end
  end

  assign dma_start = dma_start_r;

endmodule // rx_cfg_rom_regs

// ==== src/rx_cfg_pkg.sv ====
// package: offsets, field layout, reset values, timing and carriers for the
// receive configuration and serial rom command registers
// assumes a 25 MHz core clock and a plain word-wide register port
package rx_cfg_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] RX_CFG_OFF = 8'h44;
  localparam logic [7:0] ROM_CMD_OFF = 8'h50;

  // receive configuration field positions
  localparam int SFCC_BIT = 16;
  localparam int THR_LSB = 13;
  localparam int BURST_LSB = 8;
  localparam int ROM_TYPE_BIT = 6;
  localparam int AERR_BIT = 5;
  localparam int ARUNT_BIT = 4;
  localparam int ABC_BIT = 3;
  localparam int AMC_BIT = 2;
  localparam int APM_BIT = 1;
  localparam int AALL_BIT = 0;
  localparam logic [31:0] RX_CFG_WMASK = 32'h0001_E73F;
  localparam logic [31:0] RX_CFG_RESET = 32'h0000_E700;

  // serial rom command field positions
  localparam int MODE_LSB = 6;
  localparam int SEL_BIT = 3;
  localparam int CLK_BIT = 2;
  localparam int DIN_BIT = 1;
  localparam int DOUT_BIT = 0;

  // size codes shared by threshold and burst limit
  localparam logic [2:0] SIZE_64 = 3'h2;
  localparam logic [2:0] SIZE_NONE = 3'h7;

  // length limits
  localparam logic [15:0] SHORT_LEN = 16'h0008;
  localparam logic [15:0] MIN_LEN = 16'h0040;

  // timing
  localparam int CLK_MHZ = 25;
  localparam int AUTOLOAD_US = 2000;
  localparam int AUTOLOAD_CYCLES = AUTOLOAD_US * CLK_MHZ;

  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_AUTOLOAD,
    MODE_PROGRAM,
    MODE_CFG_WRITE
  } rom_mode_t;

  // one received packet's attributes, as the mac sees them
  typedef struct packed {
    logic [15:0] len;
    logic crc_err;
    logic align_err;
    logic collided;
    logic is_bcast;
    logic is_mcast;
    logic phys_match;
  } rx_pkt_t;

  // serial rom pins driven by the device
  typedef struct packed {
    logic serial_rom_select;
    logic serial_rom_clock;
    logic serial_rom_din;
  } rom_pins_t;

endpackage

// ==== test/rx_cfg_rom_regs_properties.sv ====
// checker: port timing of the receive config and rom command block
// assumes one clock, bound onto every rx_cfg_rom_regs instance
module rx_cfg_rom_regs_chk
  import rx_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic pkt_valid,
  input wire rx_cfg_pkg::rx_pkt_t pkt,
  input wire logic verdict_valid,
  input wire logic pkt_accept,
  input wire logic crc_check,
  input wire logic fifo_pkt_complete,
  input wire logic dma_start,
  input wire logic [10:0] burst_bytes,
  input wire logic burst_unlimited,
  input wire logic bus_master_en,
  input wire logic setup_write_en,
  input wire logic regs_default,
  input wire rx_cfg_pkg::rom_pins_t rom_pins
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ----
  // assertions
  // ----
  a_verdict_next: assert property (pkt_valid |=> verdict_valid)
    else $error("verdict missing");
  a_verdict_stray: assert property (!pkt_valid |=> !verdict_valid)
    else $error("stray verdict");
  a_crc_short: assert property (verdict_valid && crc_check |-> $past(pkt.len) > SHORT_LEN)
    else $error("crc on short frame");
  a_crc_long: assert property (verdict_valid && $past(pkt.len) > MIN_LEN |-> crc_check)
    else $error("no crc on long frame");
  a_runt_drop: assert property (verdict_valid && $past(pkt.len) < SHORT_LEN |-> !pkt_accept)
    else $error("tiny frame accepted");
  a_rdata_idle: assert property (!rd |=> rdata == '0)
    else $error("rdata without read");
  a_prog_dma: assert property (!bus_master_en ##1 !bus_master_en |-> !dma_start)
    else $error("dma while halted");
  a_pins_hidden: assert property (bus_master_en |-> rom_pins == '0)
    else $error("rom pins driven");
  a_setup_mode: assert property (setup_write_en |-> bus_master_en)
    else $error("setup mode halts bus");
  a_burst_unl: assert property (burst_unlimited |-> burst_bytes == '0)
    else $error("unlimited with size");
  a_complete_dma: assert property (fifo_pkt_complete && bus_master_en |=> dma_start)
    else $error("dma not started");
  // main scenarios reached
  c_accept: cover property (verdict_valid && pkt_accept);
  c_reload: cover property (regs_default);
  c_dma: cover property (dma_start);
endmodule // rx_cfg_rom_regs_chk

bind rx_cfg_rom_regs rx_cfg_rom_regs_chk u_rx_cfg_rom_regs_chk (.clk, .rst, .rd, .rdata, .pkt_valid,
  .pkt, .verdict_valid, .pkt_accept, .crc_check, .fifo_pkt_complete, .dma_start, .burst_bytes,
  .burst_unlimited, .bus_master_en, .setup_write_en, .regs_default, .rom_pins);

// ==== test/tb.sv ====
// testbench: drives every port of the register block and judges replies
// assumes rx_cfg_pkg and the checker are compiled first
module tb import rx_cfg_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int AL = 8;
  logic clk = 0, rst = 1, wr = 0, rd = 0, pkt_valid = 0;
  logic fifo_pkt_complete = 0, flash_sel = 0, boot_rom_done = 1;
  logic rom_type_pin = 0, serial_rom_dout = 0;
  logic [7:0] addr = '0;
  logic [31:0] wdata = '0;
  logic [15:0] fifo_bytes = '0;
  rx_pkt_t pkt = '0;
  logic [31:0] rdata;
  logic verdict_valid, pkt_accept, crc_check, dma_start, burst_unlimited;
  logic bus_master_en, setup_write_en, regs_default;
  logic [10:0] burst_bytes;
  rom_pins_t rom_pins;
  int failures = 0, cmp_count = 0;
  // ----
  // block and clock
  // ----
  // auto-load shortened so the reload fits a short run
  rx_cfg_rom_regs #(.AUTOLOAD_LEN(AL)) u_rx_cfg_rom_regs (.clk, .rst, .addr, .wdata, .wr, .rd,
    .rdata, .pkt_valid, .pkt, .verdict_valid, .pkt_accept, .crc_check, .fifo_bytes,
    .fifo_pkt_complete, .dma_start, .burst_bytes, .burst_unlimited, .bus_master_en,
    .setup_write_en, .regs_default, .flash_sel, .boot_rom_done, .rom_type_pin, .rom_pins,
    .serial_rom_dout);
  always #20 clk = ~clk;
  // ----
  // shared tasks
  // ----
  task automatic chk(input string n, input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'h1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'h0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    rd <= 1'h1;
    addr <= a;
    @(posedge clk);
    rd <= 1'h0;
    #1 chk("rdata", rdata, e);
  endtask
  // f holds crc error, broadcast, multicast, physical match
  task automatic pk(input logic [15:0] l, input logic [3:0] f, input logic a, c);
    @(posedge clk);
    pkt_valid <= 1'h1;
    pkt <= '{l, f[3], 1'h0, 1'h0, f[2], f[1], f[0]};
    @(posedge clk);
    pkt_valid <= 1'h0;
    #1 chk("accept", pkt_accept, a);
    chk("crc", crc_check, c);
    chk("verdict", verdict_valid, 1'h1);
  endtask
  // two edges: the start registers from the new count on the first, the second is spare
  task automatic fb(input logic [15:0] v, input logic e);
    @(posedge clk);
    fifo_bytes <= v;
    repeat (2) @(posedge clk);
    #1 chk("dma", dma_start, e);
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_reset();
    rchk(RX_CFG_OFF, 32'h0000_E700);
    rchk(ROM_CMD_OFF, 32'h0000_0000);
    chk("master", bus_master_en, 1'h1);
    rchk(8'h48, 32'h0000_0000);
    wr_reg(RX_CFG_OFF, 32'hFFFF_FFFF);
    rchk(RX_CFG_OFF, 32'h0001_E73F);
  endtask
  task automatic t_filter();
    wr_reg(RX_CFG_OFF, 32'h0000_E708);
    pk(16'h0040, 4'h4, 1'h1, 1'h0);
    pk(16'h0041, 4'h4, 1'h1, 1'h1);
    pk(16'h0064, 4'hC, 1'h0, 1'h1);
    pk(16'h0064, 4'h2, 1'h0, 1'h1);
    wr_reg(RX_CFG_OFF, 32'h0001_E708);
    pk(16'h0009, 4'h4, 1'h0, 1'h1);
    pk(16'h0008, 4'h4, 1'h0, 1'h0);
    wr_reg(RX_CFG_OFF, 32'h0000_E718);
    pk(16'h0007, 4'h4, 1'h0, 1'h0);
    pk(16'h0008, 4'h4, 1'h1, 1'h0);
    pk(16'h0009, 4'h4, 1'h1, 1'h1);
    wr_reg(RX_CFG_OFF, 32'h0000_E728);
    pk(16'h0064, 4'hC, 1'h1, 1'h1);
    pk(16'h0009, 4'h4, 1'h0, 1'h1);
    wr_reg(RX_CFG_OFF, 32'h0000_E706);
    pk(16'h0064, 4'h2, 1'h1, 1'h1);
    pk(16'h0064, 4'h1, 1'h1, 1'h1);
    pk(16'h0064, 4'h4, 1'h0, 1'h1);
    wr_reg(RX_CFG_OFF, 32'h0000_E701);
    pk(16'h0064, 4'h0, 1'h1, 1'h1);
  endtask
  task automatic t_dma();
    logic [15:0] n;
    for (int c = 2; c < 7; c++) begin
      n = 16'h0040 << (c - 2);
      wr_reg(RX_CFG_OFF, {16'h0000, c[2:0], 2'h0, c[2:0], 8'h00});
      #1 chk("burst", burst_bytes, n);
      fb(n - 16'h0001, 1'h0);
      fb(n, 1'h1);
    end
    wr_reg(RX_CFG_OFF, 32'h0000_E700);
    #1 chk("unlimited", burst_unlimited, 1'h1);
    fb(16'h07FF, 1'h0);
    @(posedge clk);
    fifo_pkt_complete <= 1'h1;
    fb(16'h0000, 1'h1);
  endtask
  // complete packet stays held so the halt must hold dma off
  task automatic t_modes();
    @(posedge clk);
    serial_rom_dout <= 1'h1;
    wr_reg(ROM_CMD_OFF, 32'h0000_008F);
    #1 chk("master", bus_master_en, 1'h0);
    chk("pins", rom_pins, 3'h7);
    fb(16'h0000, 1'h0);
    rchk(ROM_CMD_OFF, 32'h0000_008F);
    @(posedge clk);
    flash_sel <= 1'h1;
    rchk(ROM_CMD_OFF, 32'h0000_0080);
    @(posedge clk);
    flash_sel <= 1'h0;
    boot_rom_done <= 1'h0;
    rchk(ROM_CMD_OFF, 32'h0000_0088);
    wr_reg(ROM_CMD_OFF, 32'h0000_00C0);
    #1 chk("setup", setup_write_en, 1'h1);
    chk("master", bus_master_en, 1'h1);
    wr_reg(ROM_CMD_OFF, 32'h0000_0000);
    #1 chk("setup", setup_write_en, 1'h0);
    @(posedge clk);
    fifo_pkt_complete <= 1'h0;
  endtask
  // the write issued mid reload must be dropped
  task automatic t_auto();
    int k;
    @(posedge clk);
    rom_type_pin <= 1'h1;
    wr_reg(RX_CFG_OFF, 32'h0001_E73F);
    wr_reg(ROM_CMD_OFF, 32'h0000_0040);
    #1 chk("master", bus_master_en, 1'h0);
    wr_reg(ROM_CMD_OFF, 32'h0000_00C0);
    k = 0;
    while (regs_default !== 1'h1 && k < 20) begin
      @(posedge clk);
      #1;
      k++;
    end
    // the wait starts two edges into the reload, which lasts AL cycles
    chk("reload", k, AL - 2);
    rchk(ROM_CMD_OFF, 32'h0000_0000);
    rchk(RX_CFG_OFF, 32'h0000_E740);
  endtask
  task automatic complete_run();
    if (failures == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ----
  // sequence and watchdog
  // ----
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    t_reset();
    t_filter();
    t_dma();
    t_modes();
    t_auto();
    complete_run();
  end
  // run needs about 140 cycles, so 100 us means a hang
  initial begin
    #100000;
    failures++;
    complete_run();
  end
endmodule // tb
